// ### common/hw_standby_pkg.sv
// Purpose: shared constants and carriers for the hardware standby control
// Assumes: one system clock; slow crystal clock arrives as a plain input
// Notes:   sizes, lanes and three output reset values used by the design live here
package hw_standby_pkg;

   // ************************************************************
   // clocks
   // ************************************************************
   localparam int unsigned SYS_CLK_HZ        = 40000000;
   localparam int unsigned SLOW_CLK_HZ       = 32768;

   // ************************************************************
   // request qualifier
   // ************************************************************
   localparam int unsigned SYNC_STAGES       = 2;
   localparam int unsigned QUAL_LOW_SAMPLES  = 2;
   localparam int unsigned QUAL_CNT_W        = 2;
   localparam logic [1:0]  QUAL_CNT_RESET    = 2'h0;

   // synchroniser lanes
   localparam int unsigned LANE_REQ          = 0;
   localparam int unsigned LANE_SLOW         = 1;
   localparam int unsigned LANE_POR          = 2;
   localparam int unsigned LANES             = 3;
   localparam logic [2:0]  LANE_RESET        = 3'h5;

   // ************************************************************
   // reset values of outputs
   // ************************************************************
   localparam logic        HW_STANDBY_RESET  = 1'b0;
   localparam logic        OSC_ENABLE_RESET  = 1'b1;
   localparam logic        TIMER_CLK_RESET   = 1'b0;

   // ************************************************************
   // carriers
   // ************************************************************
   typedef struct packed {
      logic sw_standby;     // clocks stopped by software standby
      logic wdt_settling;   // settling watchdog counting after a wake
      logic sleep;          // processor in sleep mode
      logic cpu_running;    // processor executing instructions
   } clock_pulse_generator_state_s;

   typedef struct packed {
      logic irq;            // interrupt request
      logic manual_reset;   // manual reset request
      logic timer_run;      // interval timer unit start request
      logic timer_clock;    // timer clock from the interval timer unit
   } module_request_s;

   typedef enum logic [2:0] {
      ST_NORMAL,
      ST_WAIT_WAKE,
      ST_CANCEL_SLEEP,
      ST_HW_STANDBY,
      ST_OSC_START
   } standby_state_e;

endpackage : hw_standby_pkg

// ### verilog/standby_request_qualifier.sv
// Purpose: synchronise request, slow clock and reset pins; qualify request
// Assumes: slow clock is far slower than the system clock
// Notes:   recognition is a level that holds while the pin stays low
`timescale 1ns/100ps

module standby_request_qualifier (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic req_n_pin,
   input  wire logic slow_clk_pin,
   input  wire logic por_n_pin,
   output logic      req_recognized,
   output logic      req_high,
   output logic      por_n
);

   // ************************************************************
   // two-flop synchronisers, one per lane
   // ************************************************************
   logic [hw_standby_pkg::LANES-1:0] pins;
   logic [hw_standby_pkg::LANES-1:0] meta_q;
   logic [hw_standby_pkg::LANES-1:0] sync_q;

   assign pins = {por_n_pin, slow_clk_pin, req_n_pin};

   genvar g;
   generate
      for (g = 0; g < hw_standby_pkg::LANES; g++) begin : g_sync
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               meta_q[g] <= hw_standby_pkg::LANE_RESET[g];
               sync_q[g] <= hw_standby_pkg::LANE_RESET[g];
            end else begin
               meta_q[g] <= pins[g];
               sync_q[g] <= meta_q[g]; // see [R15]
            end
         end
      end
   endgenerate

   // ************************************************************
   // slow-clock sampling and low counter
   // ************************************************************
   logic                                   slow_last_q;
   logic                                   slow_last_d;
   logic [hw_standby_pkg::QUAL_CNT_W-1:0]  low_cnt_q;
   logic [hw_standby_pkg::QUAL_CNT_W-1:0]  low_cnt_d;
   logic                                   slow_rise;

   always_comb begin
      slow_last_d = sync_q[hw_standby_pkg::LANE_SLOW];
      slow_rise   = sync_q[hw_standby_pkg::LANE_SLOW] & ~slow_last_q;
      low_cnt_d   = low_cnt_q;
      if (slow_rise) begin
         if (sync_q[hw_standby_pkg::LANE_REQ]) begin
            low_cnt_d = hw_standby_pkg::QUAL_CNT_RESET; // see [R15]
         end else if (low_cnt_q !=
                      hw_standby_pkg::QUAL_CNT_W'(
                         hw_standby_pkg::QUAL_LOW_SAMPLES)) begin
            low_cnt_d = low_cnt_q + 1'b1; // see [R13]
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         slow_last_q <= 1'b0;
         low_cnt_q   <= hw_standby_pkg::QUAL_CNT_RESET;
      end else begin
         slow_last_q <= slow_last_d;
         low_cnt_q   <= low_cnt_d;
      end
   end

   // two consecutive low samples on slow edges
   assign req_recognized = (low_cnt_q == hw_standby_pkg::QUAL_CNT_W'(
                               hw_standby_pkg::QUAL_LOW_SAMPLES)); // see [R13]
   assign req_high       = sync_q[hw_standby_pkg::LANE_REQ];
   assign por_n          = sync_q[hw_standby_pkg::LANE_POR];

endmodule : standby_request_qualifier

// ### verilog/hardware_standby_control.sv
// Purpose: pin-driven hardware standby entry and exit for the processor
// Assumes: request, slow clock and reset pins synchronous to SYS_CLK after the qualifier stages
// Notes:   exit only through the power-on reset pin sequence
//
// Functional notes
// [R1] A recognised low request enters standby and halts non-slow modules.
// [R2] In hardware standby interrupts and manual resets are not passed on.
// [R3] In hardware standby the interval timer unit is held stopped.
// [R4] From software standby the clock stays stopped and timer clock is low.
// [R5] During wake settling the wake finishes and the processor resumes first.
// [R6] In sleep, sleep is cancelled and the processor resumes first.
// [R7] The power controller holds the request pin low for the whole standby.
// [R8] Only a power-on reset sequence leaves hardware standby.
// [R9] Request high while reset pin low restarts clock oscillation.
// [R10] The power controller holds reset low until oscillation is stable.
// [R11] Reset pin going high afterwards starts power-on reset processing.
// [R12] The power controller sends no interrupts or manual resets meanwhile.
// [R13] The request pin is sampled on the slow clock and needs two low reads.
// [R14] Clocks return after a wake only when the settling time has elapsed.
// [R15] A high sample restarts the qualifier; pins pass two sync flip-flops.
`timescale 1ns/100ps

module hardware_standby_control (
   input  wire logic                                         SYS_CLK,
   input  wire logic                                         RST,
   input  wire logic                                         HW_STANDBY_REQUEST_N,
   input  wire logic                                         SLOW_CRYSTAL_CLOCK,
   input  wire logic                                         POWER_ON_RESET_N,
   input  wire hw_standby_pkg::clock_pulse_generator_state_s CPG_STATE_IN,
   input  wire hw_standby_pkg::module_request_s              MODULE_REQ,
   output logic                                              HW_STANDBY,
   output logic                                              MODULE_HALT,
   output logic                                              CLOCK_STOP,
   output logic                                              OSC_ENABLE,
   output logic                                              SLEEP_CANCEL,
   output logic                                              IRQ_OUT,
   output logic                                              MANUAL_RESET_OUT,
   output logic                                              INTERVAL_TIMER_UNIT_EN,
   output logic                                              TIMER_CLOCK_OUTPUT,
   output logic                                              CPU_RESET_HOLD,
   output logic                                              POR_START
);

   // ************************************************************
   // pin qualification
   // ************************************************************
   logic req_recognized;
   logic req_high;
   logic por_n;

   standby_request_qualifier u_qual (
      .clk            (SYS_CLK),
      .rst            (RST),
      .req_n_pin      (HW_STANDBY_REQUEST_N),
      .slow_clk_pin   (SLOW_CRYSTAL_CLOCK),
      .por_n_pin      (POWER_ON_RESET_N),
      .req_recognized (req_recognized),
      .req_high       (req_high),
      .por_n          (por_n)
   );

   // ************************************************************
   // registered view of the clock generator state
   // ************************************************************
   // one register stage keeps the state decode off raw input timing
   hw_standby_pkg::clock_pulse_generator_state_s cpg_q;
   hw_standby_pkg::clock_pulse_generator_state_s cpg_d;

   always_comb begin
      cpg_d = CPG_STATE_IN;
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         cpg_q <= '0;
      end else begin
         cpg_q <= cpg_d;
      end
   end

   // ************************************************************
   // standby state machine
   // ************************************************************
   hw_standby_pkg::standby_state_e state_q;
   hw_standby_pkg::standby_state_e state_d;
   logic                           wake_done;
   logic                           sleep_done;

   // the processor must be seen running before standby is taken after a wake or a sleep cancel
   always_comb begin
      wake_done  = ~cpg_q.wdt_settling & ~cpg_q.sw_standby &
                   cpg_q.cpu_running; // see [R14]
      sleep_done = ~cpg_q.sleep & cpg_q.cpu_running;
   end

   always_comb begin
      state_d = state_q;
      case (state_q)
         hw_standby_pkg::ST_NORMAL: begin
            if (req_recognized) begin
               if (cpg_q.wdt_settling) begin
                  state_d = hw_standby_pkg::ST_WAIT_WAKE; // see [R5]
               end else if (cpg_q.sleep) begin
                  state_d = hw_standby_pkg::ST_CANCEL_SLEEP; // see [R6]
               end else begin
                  // running or software standby: straight in
                  state_d = hw_standby_pkg::ST_HW_STANDBY; // see [R1] [R4]
               end
            end
         end
         hw_standby_pkg::ST_WAIT_WAKE: begin
            // committed once taken, a late high request does not abort
            if (wake_done) begin
               state_d = hw_standby_pkg::ST_HW_STANDBY; // see [R5]
            end
         end
         hw_standby_pkg::ST_CANCEL_SLEEP: begin
            if (sleep_done) begin
               state_d = hw_standby_pkg::ST_HW_STANDBY; // see [R6]
            end
         end
         hw_standby_pkg::ST_HW_STANDBY: begin
            // request high with reset high is not a power-on reset
            if (req_high && !por_n) begin
               state_d = hw_standby_pkg::ST_OSC_START; // see [R8] [R9]
            end
         end
         hw_standby_pkg::ST_OSC_START: begin
            // oscillation runs, processor held until reset pin releases
            if (por_n) begin
               state_d = hw_standby_pkg::ST_NORMAL; // see [R11]
            end
         end
         default: begin
            state_d = hw_standby_pkg::ST_NORMAL;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         state_q <= hw_standby_pkg::ST_NORMAL;
      end else begin
         state_q <= state_d;
      end
   end

   // ************************************************************
   // output decode
   // ************************************************************
   // decoded from the next state so the flops track the state exactly
   logic hw_standby_d;
   logic module_halt_d;
   logic clock_stop_d;
   logic osc_enable_d;
   logic sleep_cancel_d;
   logic irq_out_d;
   logic manual_reset_out_d;
   logic timer_unit_en_d;
   logic timer_clock_d;
   logic cpu_reset_hold_d;
   logic por_start_d;
   logic in_standby_d;

   always_comb begin
      in_standby_d = (state_d == hw_standby_pkg::ST_HW_STANDBY) ||
                     (state_d == hw_standby_pkg::ST_OSC_START);
      hw_standby_d = in_standby_d;
      // every module except the slow-clock ones stops
      module_halt_d = in_standby_d; // see [R1]
      // clock stays stopped until the request is released with the reset pin low
      clock_stop_d = (state_d == hw_standby_pkg::ST_HW_STANDBY); // see [R4]
      osc_enable_d = ~clock_stop_d; // see [R9]
      sleep_cancel_d = (state_d == hw_standby_pkg::ST_CANCEL_SLEEP); // see [R6]
      // requests are dropped, not deferred, while in standby
      irq_out_d = MODULE_REQ.irq & ~in_standby_d; // see [R2]
      manual_reset_out_d = MODULE_REQ.manual_reset &
                           ~in_standby_d; // see [R2]
      timer_unit_en_d = MODULE_REQ.timer_run & ~in_standby_d; // see [R3]
      timer_clock_d = in_standby_d ? 1'b0 :
                      MODULE_REQ.timer_clock; // see [R4]
      cpu_reset_hold_d = (state_d == hw_standby_pkg::ST_OSC_START); // see [R10]
      por_start_d = (state_q == hw_standby_pkg::ST_OSC_START) &&
                    (state_d == hw_standby_pkg::ST_NORMAL); // see [R11]
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         HW_STANDBY             <= hw_standby_pkg::HW_STANDBY_RESET;
         MODULE_HALT            <= 1'b0;
         CLOCK_STOP             <= 1'b0;
         OSC_ENABLE             <= hw_standby_pkg::OSC_ENABLE_RESET;
         SLEEP_CANCEL           <= 1'b0;
         IRQ_OUT                <= 1'b0;
         MANUAL_RESET_OUT       <= 1'b0;
         INTERVAL_TIMER_UNIT_EN <= 1'b0;
         TIMER_CLOCK_OUTPUT     <= hw_standby_pkg::TIMER_CLK_RESET;
         CPU_RESET_HOLD         <= 1'b0;
         POR_START              <= 1'b0;
      end else begin
         HW_STANDBY             <= hw_standby_d;
         MODULE_HALT            <= module_halt_d;
         CLOCK_STOP             <= clock_stop_d;
         OSC_ENABLE             <= osc_enable_d;
         SLEEP_CANCEL           <= sleep_cancel_d;
         IRQ_OUT                <= irq_out_d;
         MANUAL_RESET_OUT       <= manual_reset_out_d;
         INTERVAL_TIMER_UNIT_EN <= timer_unit_en_d;
         TIMER_CLOCK_OUTPUT     <= timer_clock_d;
         CPU_RESET_HOLD         <= cpu_reset_hold_d;
         POR_START              <= por_start_d;
      end
   end

endmodule : hardware_standby_control

// ### test/hardware_standby_control_monitor.sv
// Purpose: port checker for hardware standby control
// Assumes: raw pins seen here lead the design's synchronised copies
// Notes:   bound to the top module at the foot of this file
`timescale 1ns/100ps

module hardware_standby_control_monitor (
   input wire logic                                         SYS_CLK,
   input wire logic                                         RST,
   input wire logic                                         HW_STANDBY_REQUEST_N,
   input wire logic                                         SLOW_CRYSTAL_CLOCK,
   input wire hw_standby_pkg::clock_pulse_generator_state_s CPG_STATE_IN,
   input wire logic                                         HW_STANDBY,
   input wire logic                                         MODULE_HALT,
   input wire logic                                         CLOCK_STOP,
   input wire logic                                         OSC_ENABLE,
   input wire logic                                         SLEEP_CANCEL,
   input wire logic                                         IRQ_OUT,
   input wire logic                                         MANUAL_RESET_OUT,
   input wire logic                                         INTERVAL_TIMER_UNIT_EN,
   input wire logic                                         TIMER_CLOCK_OUTPUT,
   input wire logic                                         CPU_RESET_HOLD,
   input wire logic                                         POR_START
);
   // *****
   // two-low tracker on raw pins
   // *****
   logic       slow_q, slow_d, seen_q, seen_d;
   logic [1:0] low_q, low_d;
   always_comb begin
      slow_d = SLOW_CRYSTAL_CLOCK;
      low_d  = low_q;
      seen_d = seen_q & ~POR_START;
      if (SLOW_CRYSTAL_CLOCK && !slow_q) begin
         low_d  = HW_STANDBY_REQUEST_N ? 2'h0 : {1'b1, low_q[1]};
         seen_d = seen_d | (low_d == 2'h3);
      end
   end
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         slow_q <= 1'b0;
         low_q  <= 2'h0;
         seen_q <= 1'b0;
      end else begin
         slow_q <= slow_d;
         low_q  <= low_d;
         seen_q <= seen_d;
      end
   end
   // *****
   // assertions
   // *****
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   sequence s_enter;
      $rose(HW_STANDBY);
   endsequence
   sequence s_restart;
      $rose(CPU_RESET_HOLD);
   endsequence
   a_osc_mirror: assert property (OSC_ENABLE != CLOCK_STOP)
      else $error("osc enable not inverse of clock stop");
   a_entry_halt: assert property (
      s_enter |-> MODULE_HALT && CLOCK_STOP && !OSC_ENABLE)
      else $error("entry without halt");
   a_no_accept: assert property (
      HW_STANDBY |-> !IRQ_OUT && !MANUAL_RESET_OUT)
      else $error("request passed in standby");
   a_timer_halt: assert property (
      HW_STANDBY |-> !INTERVAL_TIMER_UNIT_EN)
      else $error("timer runs in standby");
   a_timer_clock_output_low: assert property (HW_STANDBY |-> !TIMER_CLOCK_OUTPUT)
      else $error("timer clock not low");
   a_exit_por: assert property ($fell(HW_STANDBY) |-> POR_START)
      else $error("exit without reset start");
   a_por_pulse: assert property (
      POR_START |-> !HW_STANDBY && $past(CPU_RESET_HOLD) ##1 !POR_START)
      else $error("bad reset start pulse");
   a_osc_restart: assert property (
      s_restart |-> HW_STANDBY && !CLOCK_STOP && $past(CLOCK_STOP))
      else $error("bad oscillator restart");
   a_two_lows: assert property (s_enter |-> seen_q)
      else $error("entry without two low samples");
   a_wake_first: assert property (
      s_enter |-> !$past(CPG_STATE_IN.wdt_settling)
                  && !$past(CPG_STATE_IN.sleep))
      else $error("entry before wake or sleep cancel");
   a_cancel_done: assert property (
      $fell(SLEEP_CANCEL) |-> ##[0:2] HW_STANDBY)
      else $error("no entry after sleep cancel");
endmodule : hardware_standby_control_monitor

bind hardware_standby_control hardware_standby_control_monitor u_mon (
   .SYS_CLK(SYS_CLK), .RST(RST), .HW_STANDBY_REQUEST_N(HW_STANDBY_REQUEST_N),
   .SLOW_CRYSTAL_CLOCK(SLOW_CRYSTAL_CLOCK), .CPG_STATE_IN(CPG_STATE_IN),
   .HW_STANDBY(HW_STANDBY), .MODULE_HALT(MODULE_HALT),
   .CLOCK_STOP(CLOCK_STOP), .OSC_ENABLE(OSC_ENABLE),
   .SLEEP_CANCEL(SLEEP_CANCEL), .IRQ_OUT(IRQ_OUT),
   .MANUAL_RESET_OUT(MANUAL_RESET_OUT),
   .INTERVAL_TIMER_UNIT_EN(INTERVAL_TIMER_UNIT_EN),
   .TIMER_CLOCK_OUTPUT(TIMER_CLOCK_OUTPUT),
   .CPU_RESET_HOLD(CPU_RESET_HOLD), .POR_START(POR_START));

// ### test/power_controller_model.sv
// Purpose: system power controller driving request, reset and slow clock
// Assumes: slow clock shortened; the design samples it as plain data
// Notes:   set_req moves the request on slow falling edges, far from sampling
`timescale 1ns/100ps

module power_controller_model (
   input  wire logic sys_clk,
   output logic      req_n,
   output logic      por_n,
   output logic      slow_clk
);
   localparam int SLOW_HALF = 16; // short period keeps the run brief
   int cnt;
   initial begin
      req_n    = 1'b1;
      por_n    = 1'b1; // no interrupt lines here
      slow_clk = 1'b0;
      cnt      = 0;
   end
   always @(negedge sys_clk) begin
      cnt = (cnt == SLOW_HALF - 1) ? 0 : cnt + 1;
      if (cnt == 0) slow_clk = ~slow_clk;
   end
   task automatic set_req(input logic v);
      @(negedge slow_clk);
      req_n = v; // held low for all of standby
   endtask : set_req
   task automatic start_exit(input int settle);
      por_n = 1'b0; // reset first
      repeat (4) @(negedge sys_clk);
      req_n = 1'b1;
      repeat (settle) @(negedge sys_clk); // oscillator settling
   endtask : start_exit
   task automatic finish_exit();
      por_n = 1'b1;
   endtask : finish_exit
endmodule : power_controller_model

// ### test/hardware_standby_control_tb_top.sv
// Purpose: self-checking bench for hardware standby control
// Assumes: partner model owns request, reset and slow clock pins
// Notes:   every entry scenario also leaves standby by the reset pins
`timescale 1ns/100ps

module hardware_standby_control_tb_top;
   logic sys_clk, rst, req_n, slow_clk, por_n;
   logic hw_sb, halt, clk_stop, osc_en, slp_cancel, irq_o, mrst_o;
   logic itu_en, tmr_o, cpu_hold, por_start;
   hw_standby_pkg::clock_pulse_generator_state_s clock_pulse_generator;
   hw_standby_pkg::module_request_s              mreq;
   int n_fail, n_compared;

   always #12.5 sys_clk = ~sys_clk;

   power_controller_model u_pc (.sys_clk(sys_clk), .req_n(req_n),
      .por_n(por_n), .slow_clk(slow_clk));
   hardware_standby_control DUT (.SYS_CLK(sys_clk), .RST(rst),
      .HW_STANDBY_REQUEST_N(req_n), .SLOW_CRYSTAL_CLOCK(slow_clk),
      .POWER_ON_RESET_N(por_n), .CPG_STATE_IN(clock_pulse_generator), .MODULE_REQ(mreq),
      .HW_STANDBY(hw_sb), .MODULE_HALT(halt), .CLOCK_STOP(clk_stop),
      .OSC_ENABLE(osc_en), .SLEEP_CANCEL(slp_cancel), .IRQ_OUT(irq_o),
      .MANUAL_RESET_OUT(mrst_o), .INTERVAL_TIMER_UNIT_EN(itu_en),
      .TIMER_CLOCK_OUTPUT(tmr_o), .CPU_RESET_HOLD(cpu_hold),
      .POR_START(por_start));

   // *****
   // shared tasks
   // *****
   task automatic check(input logic seen, input logic exp, input string m);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask : check
   function automatic logic sel(input int k);
      case (k)
         0: return hw_sb;
         1: return slp_cancel;
         default: return por_start;
      endcase
   endfunction : sel
   task automatic wait_for(input int k, input logic v);
      int i;
      i = 0;
      while (sel(k) !== v && i < 400) begin
         @(negedge sys_clk);
         i++;
      end
      check(sel(k), v, "wait ran out");
   endtask : wait_for
   task automatic hold_and_exit();
      mreq = 4'hf; // interrupts and resets while halted
      repeat (20) @(negedge sys_clk);
      check(hw_sb, 1'b1, "left standby early");
      check(irq_o | mrst_o, 1'b0, "request accepted");
      check(itu_en, 1'b0, "timer running");
      check(tmr_o, 1'b0, "timer clock running");
      u_pc.start_exit(40);
      check(cpu_hold & osc_en & hw_sb, 1'b1, "no restart");
      check(irq_o | mrst_o | itu_en, 1'b0, "passed in restart");
      mreq = 4'h0;
      u_pc.finish_exit();
      wait_for(2, 1'b1);
      @(negedge sys_clk);
      check(hw_sb | por_start | cpu_hold, 1'b0, "exit wrong");
      check(halt | clk_stop | ~osc_en, 1'b0, "still halted");
      clock_pulse_generator = 4'h1;
   endtask : hold_and_exit
   task automatic report_and_stop();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : report_and_stop

   // *****
   // scenarios
   // *****
   task automatic t_reset();
      check(osc_en, 1'b1, "osc enable");
      check(hw_sb | halt | clk_stop | por_start, 1'b0, "reset");
   endtask : t_reset
   task automatic t_pass();
      int k;
      for (k = 0; k < 16; k++) begin
         mreq = k[3:0];
         repeat (2) @(negedge sys_clk);
         check(irq_o, mreq.irq, "irq not passed");
         check(mrst_o, mreq.manual_reset, "reset not passed");
         check(itu_en, mreq.timer_run, "timer not passed");
         check(tmr_o, mreq.timer_clock, "timer_clock_output not passed");
      end
      mreq = 4'h0;
   endtask : t_pass
   task automatic t_single();
      u_pc.set_req(1'b0);
      u_pc.set_req(1'b1);
      repeat (80) @(negedge sys_clk);
      check(hw_sb, 1'b0, "single low taken");
   endtask : t_single
   task automatic t_entry(input logic [3:0] c);
      clock_pulse_generator  = c;
      mreq = 4'h1;
      u_pc.set_req(1'b0);
      wait_for(0, 1'b1);
      check(halt & clk_stop, 1'b1, "not halted");
      check(tmr_o | osc_en, 1'b0, "clock running");
      hold_and_exit();
   endtask : t_entry
   task automatic t_wdt();
      clock_pulse_generator = 4'h4;
      u_pc.set_req(1'b0);
      repeat (150) @(negedge sys_clk);
      check(hw_sb, 1'b0, "entered while settling");
      clock_pulse_generator = 4'h1;
      wait_for(0, 1'b1);
      hold_and_exit();
   endtask : t_wdt
   task automatic t_sleep();
      clock_pulse_generator = 4'h2;
      u_pc.set_req(1'b0);
      wait_for(1, 1'b1);
      check(hw_sb, 1'b0, "entered in sleep");
      clock_pulse_generator = 4'h1;
      wait_for(0, 1'b1);
      check(slp_cancel, 1'b0, "cancel stuck");
      hold_and_exit();
   endtask : t_sleep

   initial begin
      sys_clk    = 1'b0;
      rst        = 1'b1;
      clock_pulse_generator        = 4'h1;
      mreq       = 4'h0;
      n_fail     = 0;
      n_compared = 0;
      repeat (5) @(negedge sys_clk);
      rst = 1'b0;
      repeat (4) @(negedge sys_clk);
      t_reset();
      t_pass();
      t_single();
      t_entry(4'h1);
      t_entry(4'h8);
      t_wdt();
      t_sleep();
      report_and_stop();
   end
   initial begin
      repeat (4000) @(posedge sys_clk); // about five times the expected run
      n_fail++;
      report_and_stop();
   end
endmodule : hardware_standby_control_tb_top
